// >>> design/rpa_free_divider.sv
// Free-running binary divider chain cleared only by reset
`timescale 1ns/100ps
`default_nettype none
module rpa_free_divider #(
  parameter int WIDTH = 18
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  output logic      [WIDTH-1:0] count
);
  import rpa_pkg::*;

  // Refuse a chain too short to be a divider
  if (WIDTH < 2) begin : g_width_check
    $error("rpa_free_divider: WIDTH must be at least 2");
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= count + WIDTH'(1);
    end
  end

endmodule : rpa_free_divider
`default_nettype wire

// >>> design/rpa_input_sync.sv
// Two-stage synchroniser for the accumulator input pin
`timescale 1ns/100ps
`default_nettype none
module rpa_input_sync (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic pinIn,
  output logic      pinSync
);
  import rpa_pkg::*;

  logic firstStage;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      firstStage <= 1'b0;
      pinSync    <= 1'b0;
    end else begin
      firstStage <= pinIn;
      pinSync    <= firstStage;
    end
  end

endmodule : rpa_input_sync
`default_nettype wire

// >>> design/rpa_pkg.sv
// Shared constants, register map and carrier types of the periodic timer and pulse accumulator
package rpa_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] ADDR_MASK_TWO = 8'h24;
  localparam logic [7:0] ADDR_FLAG_TWO = 8'h25;
  localparam logic [7:0] ADDR_CONTROL  = 8'h26;
  localparam logic [7:0] ADDR_COUNT    = 8'h27;

  // Reset values
  localparam logic [7:0] RST_MASK_TWO = 8'h00;
  localparam logic [7:0] RST_FLAG_TWO = 8'h00;
  localparam logic [7:0] RST_CONTROL  = 8'h00;

  // Bit positions shared by mask and flag registers
  localparam int BIT_OVERFLOW   = 7;
  localparam int BIT_PERIODIC   = 6;
  localparam int BIT_ACCUM_WRAP = 5;
  localparam int BIT_ACCUM_EDGE = 4;

  // Bit positions in the control register
  localparam int BIT_ACCUM_ENABLE = 6;
  localparam int BIT_GATED_MODE   = 5;
  localparam int BIT_EDGE_SELECT  = 4;
  localparam int BIT_CAPTURE_SEL  = 2;

  // Implemented bits of the mask, flag and control registers
  localparam logic [7:0] MASK_TWO_IMPL = 8'hF3;
  localparam logic [7:0] FLAG_TWO_IMPL = 8'hF0;
  localparam logic [7:0] CONTROL_IMPL  = 8'h77;

  // Divider taps, as powers of two of the system clock
  localparam int PERIODIC_BASE_LOG2 = 15;
  localparam int GATE_TICK_LOG2     = 8;
  localparam int RATE_STEPS_LOG2    = 3;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrStrobe;
    logic       rdStrobe;
  } rpa_bus_req_t;

  // Routing of the shared capture/compare channel
  typedef struct packed {
    logic captureFourthEn;
    logic compareFifthEn;
  } rpa_chan_sel_t;

  // Accumulator counting mode
  typedef enum logic {
    RPA_EVENT_MODE,
    RPA_GATED_MODE
  } rpa_accum_mode_t;

endpackage : rpa_pkg

// >>> design/rpa_timer_accum.sv
// Periodic interrupt timer, pulse accumulator and their mask, flag and control registers
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module rpa_timer_accum #(
  parameter int PERIOD_BASE_LOG2 = rpa_pkg::PERIODIC_BASE_LOG2,
  parameter int GATE_LOG2        = rpa_pkg::GATE_TICK_LOG2
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  // Register port
  input  wire rpa_pkg::rpa_bus_req_t busReq,
  output logic                [7:0]  rdData,
  // Wrap pulse from the main 16-bit counter
  input  wire logic                  mainCounterWrap,
  // External accumulator input pin
  input  wire logic                  accumInputPin,
  // Prescaler selection for the main timer
  output logic                [1:0]  prescaleSel,
  // Capture/compare channel routing
  output rpa_pkg::rpa_chan_sel_t     chanSel,
  // Periodic timeout pulse and combined interrupt request
  output logic                       periodicTick,
  output logic                       timerIrq
);
  import rpa_pkg::*;

  localparam int DIV_WIDTH = PERIOD_BASE_LOG2 + RATE_STEPS_LOG2;

  // Refuse settings the divider taps cannot serve
  if (PERIOD_BASE_LOG2 < 2 || GATE_LOG2 < 1 || GATE_LOG2 > DIV_WIDTH) begin : g_param_check
    $error("rpa_timer_accum: divider taps out of range");
  end

  // Register storage
  logic [7:0]      maskTwo;
  logic [7:0]      flagTwo;
  logic [7:0]      control;
  logic [7:0]      accumCount;

  // Decoded strobes
  logic            wrMask;
  logic            wrFlag;
  logic            wrControl;
  logic            wrCount;

  // Divider and timing
  logic [DIV_WIDTH-1:0] divCount;
  logic [1:0]      rateSel;
  logic            gateTick;

  // Accumulator input and its conditioning
  logic            pinSync;
  logic            pinPrev;
  logic            riseEdge;
  logic            fallEdge;
  logic            selectedEdge;
  logic            gateActive;
  logic            accumIncrement;
  logic            accumWrap;
  rpa_accum_mode_t accumMode;

  // Flag update terms
  logic [7:0]      flagSet;
  logic [7:0]      flagClear;
  logic [7:0]      next_flagTwo;

  // True when the low bits of a count are all ones
  function automatic logic lowBitsFull(input logic [DIV_WIDTH-1:0] value, input int bits);
    logic full;
    full = 1'b1;
    for (int i = 0; i < DIV_WIDTH; i++) begin
      if (i < bits) begin
        full = full & value[i];
      end
    end
    return full;
  endfunction : lowBitsFull

  // Write strobes per register
  assign wrMask    = busReq.wrStrobe && (busReq.addr == ADDR_MASK_TWO);
  assign wrFlag    = busReq.wrStrobe && (busReq.addr == ADDR_FLAG_TWO);
  assign wrControl = busReq.wrStrobe && (busReq.addr == ADDR_CONTROL);
  assign wrCount   = busReq.wrStrobe && (busReq.addr == ADDR_COUNT);

  // Free-running chain shared by the periodic timer and gated tick
  rpa_free_divider #(
    .WIDTH (DIV_WIDTH)
  ) u_divider (
    .core_clk (core_clk),
    .reset    (reset),
    .count    (divCount)
  );

  // Input pin brought into the clock domain
  rpa_input_sync u_pin_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pinIn    (accumInputPin),
    .pinSync  (pinSync)
  );

  // Mask register, implemented bits only
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      maskTwo <= RST_MASK_TWO;
    end else if (wrMask) begin
      maskTwo <= busReq.wrData & MASK_TWO_IMPL;
    end
  end

  // Control register, implemented bits only
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      control <= RST_CONTROL;
    end else if (wrControl) begin
      control <= busReq.wrData & CONTROL_IMPL;
    end
  end

  assign rateSel     = control[1:0];
  assign prescaleSel = maskTwo[1:0];

  assign periodicTick = lowBitsFull(divCount, PERIOD_BASE_LOG2 + int'(rateSel));

  assign gateTick = lowBitsFull(divCount, GATE_LOG2);

  // Delayed synchronised level for edge detection
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pinPrev <= 1'b0;
    end else begin
      pinPrev <= pinSync;
    end
  end

  assign riseEdge = pinSync & ~pinPrev;
  assign fallEdge = ~pinSync & pinPrev;

  assign accumMode = control[BIT_GATED_MODE] ? RPA_GATED_MODE : RPA_EVENT_MODE;

  assign selectedEdge = control[BIT_EDGE_SELECT] ? riseEdge : fallEdge;
  assign gateActive   = control[BIT_EDGE_SELECT] ? ~pinSync : pinSync;

  // Count enable per mode
  always_comb begin
    accumIncrement = 1'b0;
    if (control[BIT_ACCUM_ENABLE]) begin
      unique case (accumMode)
        RPA_EVENT_MODE: accumIncrement = selectedEdge;
        RPA_GATED_MODE: accumIncrement = gateTick & gateActive;
      endcase
    end
  end

  assign accumWrap = accumIncrement && (accumCount == 8'hFF) && !wrCount;

  always_ff @(posedge core_clk) begin
    if (wrCount) begin
      accumCount <= busReq.wrData;
    end else if (accumIncrement) begin
      accumCount <= accumCount + 8'h01;
    end
  end

  // Hardware set terms for the flag register
  always_comb begin
    flagSet = 8'h00;
    flagSet[BIT_OVERFLOW] = mainCounterWrap;
    flagSet[BIT_PERIODIC] = periodicTick;
    flagSet[BIT_ACCUM_WRAP] = accumWrap;
    flagSet[BIT_ACCUM_EDGE] = control[BIT_ACCUM_ENABLE] & selectedEdge;
  end

  assign flagClear = wrFlag ? (busReq.wrData & FLAG_TWO_IMPL) : 8'h00;

  assign next_flagTwo = ((flagTwo & ~flagClear) | flagSet) & FLAG_TWO_IMPL;

  // Flag register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      flagTwo <= RST_FLAG_TWO;
    end else begin
      flagTwo <= next_flagTwo;
    end
  end

  assign timerIrq = |(maskTwo[7:4] & flagTwo[7:4]);

  assign chanSel.captureFourthEn = control[BIT_CAPTURE_SEL];
  assign chanSel.compareFifthEn  = ~control[BIT_CAPTURE_SEL];

  // Read data for one cycle after the read strobe, zero otherwise
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdData <= 8'h00;
    end else if (busReq.rdStrobe) begin
      unique case (busReq.addr)
        ADDR_MASK_TWO: rdData <= maskTwo;
        ADDR_FLAG_TWO: rdData <= flagTwo & FLAG_TWO_IMPL;
        ADDR_CONTROL:  rdData <= control;
        ADDR_COUNT:    rdData <= accumCount;
        default:       rdData <= 8'h00;
      endcase
    end else begin
      rdData <= 8'h00;
    end
  end

endmodule : rpa_timer_accum
`default_nettype wire

// >>> dv/rpa_timer_accum_chk.sv
// Port checker for the periodic timer and pulse accumulator
`timescale 1ns/100ps
`default_nettype none
module rpa_timer_accum_chk #(
  parameter int PERIOD_BASE_LOG2 = 15,
  parameter int GATE_LOG2        = 8
) (
  input  wire logic                  core_clk,
  input  wire logic                  reset,
  input  wire rpa_pkg::rpa_bus_req_t busReq,
  input  wire logic [7:0]            rdData,
  input  wire logic                  mainCounterWrap,
  input  wire logic                  accumInputPin,
  input  wire logic [1:0]            prescaleSel,
  input  wire rpa_pkg::rpa_chan_sel_t chanSel,
  input  wire logic                  periodicTick,
  input  wire logic                  timerIrq
);
  import rpa_pkg::*;
  logic [31:0] cyc;
  logic [7:0]  maskSh;
  logic        maskWr;
  assign maskWr = busReq.wrStrobe && (busReq.addr == ADDR_MASK_TWO);
  // Cycles since reset, in step with the free divider
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) cyc <= '0;
    else cyc <= cyc + 32'h1;
  end
  // Shadow of the mask register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) maskSh <= 8'h00;
    else if (maskWr) maskSh <= busReq.wrData;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_tick_phase: assert property (periodicTick |-> &cyc[PERIOD_BASE_LOG2-1:0])
    else $error("periodic tick off divider phase");
  a_tick_gap: assert property (periodicTick |=> !periodicTick [*8])
    else $error("periodic ticks too close");
  a_tick_irq: assert property (periodicTick && maskSh[6] && !maskWr |=> timerIrq)
    else $error("timeout raised no request");
  a_wrap_irq: assert property (mainCounterWrap && maskSh[7] && !maskWr |=> timerIrq)
    else $error("counter wrap raised no request");
  a_irq_masked: assert property (timerIrq |-> maskSh[7:4] != 4'h0)
    else $error("request with all enables off");
  a_mask_unused: assert property ($past(busReq.rdStrobe) && $past(busReq.addr) == ADDR_MASK_TWO
    |-> rdData[3:2] == 2'b00)
    else $error("unused mask bits read nonzero");
  a_ctrl_unused: assert property ($past(busReq.rdStrobe) && $past(busReq.addr) == ADDR_CONTROL
    |-> !rdData[7] && !rdData[3])
    else $error("unused control bits read nonzero");
  a_chan_exclusive: assert property (chanSel.captureFourthEn != chanSel.compareFifthEn)
    else $error("capture and compare both or neither");
  a_presc_follow: assert property (maskWr |=> prescaleSel == maskSh[1:0])
    else $error("prescaler select not written");
  cover property (periodicTick && maskSh[6]);
  cover property (mainCounterWrap && maskSh[7]);
  cover property (busReq.rdStrobe && busReq.addr == ADDR_COUNT);
endmodule : rpa_timer_accum_chk
bind rpa_timer_accum rpa_timer_accum_chk #(.PERIOD_BASE_LOG2(PERIOD_BASE_LOG2), .GATE_LOG2(GATE_LOG2)) u_chk (
  .core_clk(core_clk), .reset(reset), .busReq(busReq), .rdData(rdData), .mainCounterWrap(mainCounterWrap),
  .accumInputPin(accumInputPin), .prescaleSel(prescaleSel), .chanSel(chanSel), .periodicTick(periodicTick),
  .timerIrq(timerIrq));
`default_nettype wire

// >>> dv/rpa_timer_accum_tb_top.sv
// Self-checking testbench for the periodic timer and pulse accumulator
`timescale 1ns/100ps
`default_nettype none
module rpa_timer_accum_tb_top;
  import rpa_pkg::*;
  localparam int PB = 4;
  logic          core_clk;
  logic          reset;
  rpa_bus_req_t  busReq;
  logic [7:0]    rdData;
  logic          mainCounterWrap;
  logic          accumInputPin;
  logic [1:0]    prescaleSel;
  rpa_chan_sel_t chanSel;
  logic          periodicTick;
  logic          timerIrq;
  int            n_errors;
  int            n_checks;
  int            cycles;
  int            n;
  logic [7:0]    v;

  rpa_timer_accum #(.PERIOD_BASE_LOG2(PB), .GATE_LOG2(2)) uut (
    .core_clk(core_clk), .reset(reset), .busReq(busReq), .rdData(rdData), .mainCounterWrap(mainCounterWrap),
    .accumInputPin(accumInputPin), .prescaleSel(prescaleSel), .chanSel(chanSel), .periodicTick(periodicTick),
    .timerIrq(timerIrq));

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busReq <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
    @(posedge core_clk);
    busReq.wrStrobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    busReq <= '{addr: a, wrData: 8'h00, wrStrobe: 1'b0, rdStrobe: 1'b1};
    @(posedge core_clk);
    busReq.rdStrobe <= 1'b0;
    @(negedge core_clk);
    d = rdData;
  endtask : rd

  // Cycles up to the next periodic tick
  task automatic gap(output int k);
    k = 0;
    repeat (300) begin
      @(negedge core_clk);
      k++;
      if (periodicTick === 1'b1) break;
    end
  endtask : gap

  // Full high then low pulses on the input pin
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge core_clk) accumInputPin <= 1'b1;
      repeat (4) @(posedge core_clk);
      accumInputPin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask : pulse

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      summarize();
    end
  end

  // Test sequence
  initial begin
    busReq = '0;
    mainCounterWrap = 1'b0;
    accumInputPin = 1'b0;
    reset = 1'b1;
    n_errors = 0;
    n_checks = 0;
    cycles = 0;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    rd(ADDR_FLAG_TWO, v); check(v, RST_FLAG_TWO);
    rd(ADDR_MASK_TWO, v); check(v, RST_MASK_TWO);
    rd(ADDR_CONTROL, v); check(v, RST_CONTROL);
    check({6'h0, chanSel}, 8'h01);
    wr(ADDR_MASK_TWO, 8'hFF);
    rd(ADDR_MASK_TWO, v); check(v, 8'hF3);
    check({6'h0, prescaleSel}, 8'h03);
    wr(ADDR_MASK_TWO, 8'h00);
    // Count has no reset value; load it before the accumulator is enabled
    wr(ADDR_COUNT, 8'h00);
    rd(ADDR_COUNT, v); check(v, 8'h00);
    wr(ADDR_CONTROL, 8'hFC);
    rd(ADDR_CONTROL, v); check(v, 8'h74);
    check({6'h0, chanSel}, 8'h02);
    wr(8'h30, 8'hFF);
    rd(8'h30, v); check(v, 8'h00);
    $display("test registers done");
    for (int r = 0; r < 4; r++) begin
      wr(ADDR_CONTROL, 8'(r));
      gap(n);
      gap(n);
      check(8'(n), 8'(16 << r));
    end
    wr(ADDR_FLAG_TWO, 8'h00);
    rd(ADDR_FLAG_TWO, v); check(v, 8'h40);
    wr(ADDR_MASK_TWO, 8'h40);
    @(negedge core_clk); check({7'h0, timerIrq}, 8'h01);
    wr(ADDR_FLAG_TWO, 8'h40);
    @(negedge core_clk); check({7'h0, timerIrq}, 8'h00);
    rd(ADDR_FLAG_TWO, v); check(v, 8'h00);
    @(posedge core_clk) mainCounterWrap <= 1'b1;
    @(posedge core_clk) mainCounterWrap <= 1'b0;
    rd(ADDR_FLAG_TWO, v); check(v, 8'h80);
    check({7'h0, timerIrq}, 8'h00);
    wr(ADDR_MASK_TWO, 8'h80);
    @(negedge core_clk); check({7'h0, timerIrq}, 8'h01);
    wr(ADDR_MASK_TWO, 8'h00);
    $display("test periodic done");
    wr(ADDR_CONTROL, 8'h53);
    wr(ADDR_FLAG_TWO, 8'hFF);
    wr(ADDR_COUNT, 8'hFE);
    pulse(1);
    rd(ADDR_COUNT, v); check(v, 8'hFF);
    rd(ADDR_FLAG_TWO, v); check(v & 8'h30, 8'h10);
    pulse(1);
    rd(ADDR_COUNT, v); check(v, 8'h00);
    rd(ADDR_FLAG_TWO, v); check(v & 8'h30, 8'h30);
    wr(ADDR_CONTROL, 8'h43);
    pulse(2);
    rd(ADDR_COUNT, v); check(v, 8'h02);
    wr(ADDR_CONTROL, 8'h03);
    wr(ADDR_FLAG_TWO, 8'hFF);
    pulse(2);
    rd(ADDR_COUNT, v); check(v, 8'h02);
    rd(ADDR_FLAG_TWO, v); check(v & 8'h30, 8'h00);
    $display("test event done");
    for (int e = 0; e < 2; e++) begin
      @(posedge core_clk) accumInputPin <= e[0];
      wr(ADDR_CONTROL, 8'h63 | 8'(e << 4));
      wr(ADDR_COUNT, 8'h00);
      repeat (40) @(posedge core_clk);
      rd(ADDR_COUNT, v); check(v, 8'h00);
      @(posedge core_clk) accumInputPin <= ~e[0];
      repeat (40) @(posedge core_clk);
      accumInputPin <= e[0];
      repeat (4) @(posedge core_clk);
      rd(ADDR_COUNT, v); check({7'h0, v inside {[8'd9:8'd11]}}, 8'h01);
    end
    $display("test gated done");
    summarize();
  end
endmodule : rpa_timer_accum_tb_top
`default_nettype wire
